// ==== eeprom_slave_consts.svh ====
// Constants for the two-wire memory slave: byte fields, reset values and timing.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef EEPROM_SLAVE_CONSTS_SVH
`define EEPROM_SLAVE_CONSTS_SVH

`define SEL_PREFIX        4'ha
`define SEL_PREFIX_MSB    7
`define SEL_PREFIX_LSB    4
`define SEL_PINS_MSB      3
`define SEL_PINS_LSB      1
`define SEL_RW_POS        0
`define ADDR_FLAG_POS     7
`define ACK_CLOCK         4'h8
`define ERASED_WORD       8'hff
`define TOTAL_ERASE_ADDR  7'h00
`define LAST_ADDR         7'h7f
`define CLK_PERIOD_NS     20
`define T_PROG_TYP_MS     10
`define T_PROG_MAX_MS     20
`define PROG_PHASE_CYCLES ((`T_PROG_TYP_MS * 1000000 / `CLK_PERIOD_NS) / 2)

`endif

// ==== eeprom_slave_pkg.sv ====
// Types for the two-wire memory slave.
// Assumes nothing of its surroundings.
package eeprom_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SELECT = 3'b001,
    ST_ADDR   = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RACK   = 3'b100,
    ST_RDATA  = 3'b101,
    ST_IGNORE = 3'b110
  } bus_state_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_ERASE = 2'b01,
    PG_WRITE = 2'b10
  } prog_state_t;

endpackage : eeprom_slave_pkg

// ==== serial_eeprom_command_slave.sv ====
// Two-wire serial slave with a 128 by 8 word store and on-chip reprogramming timer.
// Assumes scl and sda come from an outside master; sda is open drain, pulled up outside.
`timescale 1ns/100ps
`include "eeprom_slave_consts.svh"

module serial_eeprom_command_slave #(
  parameter int DEPTH        = 128,
  parameter int AW           = 7,
  parameter int PHASE_CYCLES = `PROG_PHASE_CYCLES
) (
  // System clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Serial link
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Select pins
  input  wire logic select_pin_low,
  input  wire logic select_pin_mid,
  input  wire logic select_pin_high_erase,
  input  wire logic select_high_open
);

  localparam int TW = $clog2(PHASE_CYCLES + 1);

  typedef struct packed {
    logic bit_v;
    logic tog;
  } link_t;

  typedef struct packed {
    eeprom_slave_pkg::bus_state_t  st;
    logic [3:0]                    cnt;
    logic [7:0]                    sh;
    logic [AW-1:0]                 addr;
    logic [7:0]                    wdata;
    logic                          wr_pend;
    logic                          oe_n;
    eeprom_slave_pkg::prog_state_t pg;
    logic [TW-1:0]                 tmr;
    logic                          total;
    logic [DEPTH-1:0][7:0]         mem;
    logic                          scl_s1;
    logic                          scl_s2;
    logic                          scl_s3;
    logic                          sda_s1;
    logic                          sda_s2;
    logic                          sda_s3;
    logic                          tog_s1;
    logic                          tog_s2;
    logic                          tog_s3;
    logic [2:0]                    sel_s1;
    logic [2:0]                    sel_s2;
    logic                          open_s1;
    logic                          open_s2;
  } state_t;

  link_t  l_q;
  link_t  l_d;
  state_t q;
  state_t d;

  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic sel_ok;
  logic busy;

  // The link side only captures each bit on the rising edge of scl and flags it by a toggle.
  always_comb begin
    l_d       = l_q;
    l_d.bit_v = sda_in;
    l_d.tog   = ~l_q.tog;
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // The captured bit holds for a whole scl period, so the synchronised toggle qualifies it.
  assign rise     = q.tog_s2 ^ q.tog_s3;
  assign fall     = q.scl_s3 & ~q.scl_s2;
  assign start_ev = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_ev  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign sel_ok   = (q.sh[`SEL_PREFIX_MSB:`SEL_PREFIX_LSB] == `SEL_PREFIX)
                  && (q.sh[`SEL_PINS_MSB:`SEL_PINS_LSB] == q.sel_s2);
  assign busy     = (q.pg != eeprom_slave_pkg::PG_IDLE);
  assign sda_out  = 1'b0;
  assign sda_oe_n = q.oe_n;

  always_comb begin
    d         = q;
    d.scl_s1  = scl;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = sda_in;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    d.tog_s1  = l_q.tog;
    d.tog_s2  = q.tog_s1;
    d.tog_s3  = q.tog_s2;
    d.sel_s1  = {select_pin_high_erase, select_pin_mid, select_pin_low};
    d.sel_s2  = q.sel_s1;
    d.open_s1 = select_high_open;
    d.open_s2 = q.open_s1;

    case (q.pg)
      eeprom_slave_pkg::PG_ERASE: begin
        if (q.tmr == '0) begin
          if (q.total) begin
            d.mem = '1;
            d.pg  = eeprom_slave_pkg::PG_IDLE;
          end else begin
            d.mem[q.addr] = `ERASED_WORD;
            d.pg          = (q.wdata != `ERASED_WORD) ? eeprom_slave_pkg::PG_WRITE
                                                      : eeprom_slave_pkg::PG_IDLE;
            d.tmr         = TW'(PHASE_CYCLES - 1);
          end
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      eeprom_slave_pkg::PG_WRITE: begin
        if (q.tmr == '0) begin
          d.mem[q.addr] = q.wdata;
          d.pg          = eeprom_slave_pkg::PG_IDLE;
        end else begin
          d.tmr = q.tmr - 1'b1;
        end
      end
      default: begin
        d.pg = eeprom_slave_pkg::PG_IDLE;
      end
    endcase

    if (start_ev) begin
      // repeated start drops a pending write
      d.st      = eeprom_slave_pkg::ST_SELECT;
      d.cnt     = 4'h0;
      d.oe_n    = 1'b1;
      d.wr_pend = 1'b0;
    end else if (stop_ev) begin
      if (q.wr_pend) begin
        d.total = q.open_s2 && (q.addr == `TOTAL_ERASE_ADDR) && (q.wdata == `ERASED_WORD);
        d.tmr   = TW'(PHASE_CYCLES - 1);
        if (!d.total && (q.mem[q.addr] == `ERASED_WORD)) begin
          d.pg = (q.wdata != `ERASED_WORD) ? eeprom_slave_pkg::PG_WRITE
                                           : eeprom_slave_pkg::PG_IDLE;
        end else begin
          d.pg = eeprom_slave_pkg::PG_ERASE;
        end
      end
      d.st      = eeprom_slave_pkg::ST_IDLE;
      d.cnt     = 4'h0;
      d.oe_n    = 1'b1;
      d.wr_pend = 1'b0;
    end else if (rise && (q.st != eeprom_slave_pkg::ST_IDLE)) begin
      if (q.cnt != `ACK_CLOCK) begin
        if (q.st != eeprom_slave_pkg::ST_RDATA) begin
          d.sh = {q.sh[6:0], l_q.bit_v};
        end
        d.cnt = q.cnt + 4'h1;
      end else begin
        d.cnt = 4'h0;
        if (q.st == eeprom_slave_pkg::ST_RACK) begin
          d.st = eeprom_slave_pkg::ST_RDATA;
        end else if (q.st == eeprom_slave_pkg::ST_RDATA) begin
          if (!l_q.bit_v) begin
            if (q.addr != `LAST_ADDR) begin
              d.addr = q.addr + 1'b1;
            end
          end else begin
            d.st = eeprom_slave_pkg::ST_IGNORE;
          end
        end
      end
    end else if (fall) begin
      if (q.st == eeprom_slave_pkg::ST_RDATA) begin
        if (q.cnt == `ACK_CLOCK) begin
          d.oe_n = 1'b1;
        end else if (q.cnt == 4'h0) begin
          d.sh   = q.mem[q.addr];
          d.oe_n = q.mem[q.addr][7];
        end else begin
          d.oe_n = q.sh[~q.cnt[2:0]];
        end
      end else if (q.cnt == `ACK_CLOCK) begin
        case (q.st)
          eeprom_slave_pkg::ST_SELECT: begin
            if (!sel_ok) begin
              d.st = eeprom_slave_pkg::ST_IGNORE;
            end else if (!q.sh[`SEL_RW_POS]) begin
              d.st   = eeprom_slave_pkg::ST_ADDR;
              d.oe_n = 1'b0;
              d.pg   = eeprom_slave_pkg::PG_IDLE;
            end else if (busy) begin
              d.st = eeprom_slave_pkg::ST_IGNORE;
            end else begin
              d.st   = eeprom_slave_pkg::ST_RACK;
              d.oe_n = 1'b0;
            end
          end
          eeprom_slave_pkg::ST_ADDR: begin
            if (!q.sh[`ADDR_FLAG_POS]) begin
              d.addr = q.sh[AW-1:0];
              d.st   = eeprom_slave_pkg::ST_WDATA;
              d.oe_n = 1'b0;
            end else begin
              d.st = eeprom_slave_pkg::ST_IGNORE;
            end
          end
          eeprom_slave_pkg::ST_WDATA: begin
            if (!q.wr_pend) begin
              d.wdata   = q.sh;
              d.wr_pend = 1'b1;
              d.oe_n    = 1'b0;
            end else begin
              d.st = eeprom_slave_pkg::ST_IGNORE;
            end
          end
          default: begin
            d.oe_n = 1'b1;
          end
        endcase
      end else begin
        // Acknowledge ends with the falling edge of clock nine.
        d.oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.oe_n   <= 1'b1;
      q.mem    <= '1;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  sequence s_byte_end;
    fall && (q.cnt == `ACK_CLOCK);
  endsequence

  sequence s_sel_end;
    s_byte_end ##0 (q.st == eeprom_slave_pkg::ST_SELECT) && !start_ev && !stop_ev;
  endsequence

  property p_sel_mismatch;
    @(posedge clock) disable iff (!rst_n) s_sel_end ##0 !sel_ok |=> q.oe_n [*2];
  endproperty
  a_sel_mismatch: assert property (p_sel_mismatch) else $error("ack on select mismatch");

  property p_write_ack;
    @(posedge clock) disable iff (!rst_n)
      s_sel_end ##0 sel_ok && !q.sh[0] |=> !sda_oe_n && (q.st == eeprom_slave_pkg::ST_ADDR);
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write-select not acked");

  property p_abort;
    @(posedge clock) disable iff (!rst_n) s_sel_end ##0 sel_ok && !q.sh[0] |=> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("programming not aborted");

  property p_read_busy;
    @(posedge clock) disable iff (!rst_n)
      s_sel_end ##0 sel_ok && q.sh[0] |=> (sda_oe_n == $past(busy));
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read-select ack wrong");

  property p_prog_at_stop;
    @(posedge clock) disable iff (!rst_n) $rose(busy) |-> $past(stop_ev) && $past(q.wr_pend);
  endproperty
  a_prog_at_stop: assert property (p_prog_at_stop) else $error("program without stop");

  property p_master_ack_free;
    @(posedge clock) disable iff (!rst_n)
      s_byte_end ##0 (q.st == eeprom_slave_pkg::ST_RDATA) && !start_ev && !stop_ev |=> sda_oe_n;
  endproperty
  a_master_ack_free: assert property (p_master_ack_free) else $error("line held on ack");

  property p_addr_flag;
    @(posedge clock) disable iff (!rst_n)
      s_byte_end ##0 (q.st == eeprom_slave_pkg::ST_ADDR) && q.sh[7] && !start_ev && !stop_ev
      |=> sda_oe_n && (q.st == eeprom_slave_pkg::ST_IGNORE);
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("bad address byte acked");

  property p_incr;
    @(posedge clock) disable iff (!rst_n)
      rise && (q.cnt == `ACK_CLOCK) && (q.st == eeprom_slave_pkg::ST_RDATA) && !l_q.bit_v
      && (q.addr != `LAST_ADDR) && !start_ev && !stop_ev |=> q.addr == $past(q.addr) + 1'b1;
  endproperty
  a_incr: assert property (p_incr) else $error("address not advanced");

  property p_erase_skip;
    @(posedge clock) disable iff (!rst_n)
      stop_ev && q.wr_pend && !q.open_s2 && (q.mem[q.addr] == `ERASED_WORD)
      |=> q.pg != eeprom_slave_pkg::PG_ERASE;
  endproperty
  a_erase_skip: assert property (p_erase_skip) else $error("needless erase");

endmodule : serial_eeprom_command_slave

// ==== bus_ctl.sv ====
// Two-wire bus controller model: drives the serial clock and the data line.
// Assumes the bench resolves the open-drain line with a pull-up and feeds it back.
`timescale 1ns/100ps

module bus_ctl #(
  parameter int HALF = 267
) (
  // Link clock and line level
  input  wire logic lclk,
  input  wire logic sda,
  // Driven wires
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // The short gap after each scl fall keeps data edges clear of the clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask : tick

  task automatic start;
    tick(10);
    sda_drv = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    tick(10);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b1;
    tick(HALF);
  endtask : stop

  task automatic bit_io(input logic b, output logic r);
    tick(10);
    sda_drv = b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r   = sda;
    scl = 1'b0;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(ack, r);
  endtask : rd_byte
endmodule : bus_ctl

// ==== tb.sv ====
// Self-checking bench for the two-wire memory slave.
// Assumes the slave's design files; the line has a pull-up, the select pins read 101.
`timescale 1ns/100ps
`include "eeprom_slave_consts.svh"

module tb;
  // Short programming phases keep the run brief.
  localparam int PH = 5000;
  localparam logic [2:0] PINS = 3'h5;
  logic clock, rst_n, lclk, scl, sda_drv, sda_out, sda_oe_n, sel_open;
  wire  sda;
  int   bad_count, cmp_count;

  assign sda = sda_drv & (sda_oe_n | sda_out);

  serial_eeprom_command_slave #(.PHASE_CYCLES(PH)) u_serial_eeprom_command_slave (
    .clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .select_pin_low(1'b1), .select_pin_mid(1'b0),
    .select_pin_high_erase(1'b1), .select_high_open(sel_open));

  bus_ctl u_bus_ctl (.lclk(lclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    lclk = 1'b0;
    #3;
    forever #7.5 lclk = ~lclk;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_ack(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ack

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic sel(input logic [2:0] p, input logic rw, output logic a);
    u_bus_ctl.wr_byte({`SEL_PREFIX, p, rw}, a);
  endtask : sel

  task automatic write_word(input logic [6:0] ad, input logic [7:0] v, input logic op);
    logic a;
    u_bus_ctl.start();
    sel(PINS, 1'b0, a);
    chk_ack(a, 1'b0);
    u_bus_ctl.wr_byte({1'b0, ad}, a);
    chk_ack(a, 1'b0);
    u_bus_ctl.wr_byte(v, a);
    chk_ack(a, 1'b0);
    if (op) begin
      @(posedge clock);
      #1;
      sel_open = 1'b1;
    end
    u_bus_ctl.stop();
  endtask : write_word

  task automatic poll(input logic exp, input logic [7:0] ev);
    logic       a;
    logic [7:0] d;
    u_bus_ctl.start();
    sel(PINS, 1'b1, a);
    chk_ack(a, exp);
    // Drain before stop.
    // An answered read-select drives the first bit, which would mask the stop.
    if (a === 1'b0) begin
      u_bus_ctl.rd_byte(1'b1, d);
      chk_byte(d, ev);
    end
    u_bus_ctl.stop();
  endtask : poll

  task automatic read2(input logic [6:0] ad, input logic [7:0] e0, input logic [7:0] e1);
    logic       a;
    logic [7:0] d;
    u_bus_ctl.start();
    sel(PINS, 1'b0, a);
    u_bus_ctl.wr_byte({1'b0, ad}, a);
    u_bus_ctl.start();
    sel(PINS, 1'b1, a);
    chk_ack(a, 1'b0);
    u_bus_ctl.rd_byte(1'b0, d);
    chk_byte(d, e0);
    u_bus_ctl.rd_byte(1'b1, d);
    chk_byte(d, e1);
    u_bus_ctl.stop();
  endtask : read2

  task automatic t_program;
    write_word(7'h05, 8'h3c, 1'b0);
    poll(1'b1, 8'h3c);
    // The first poll plus this wait outlasts the write; word 5 starts erased, so no erase phase runs.
    repeat (PH) @(posedge clock);
    poll(1'b0, 8'h3c);
  endtask : t_program

  task automatic t_refuse;
    logic a;
    u_bus_ctl.start();
    sel(3'h2, 1'b0, a);
    chk_ack(a, 1'b1);
    u_bus_ctl.stop();
  endtask : t_refuse

  // An abort leaves the erased word untouched, so word 6 must still read ff.
  // A flagged address byte after the abort must go unanswered.
  task automatic t_abort;
    logic a;
    write_word(7'h06, 8'h00, 1'b0);
    u_bus_ctl.start();
    sel(PINS, 1'b0, a);
    chk_ack(a, 1'b0);
    u_bus_ctl.wr_byte(8'h86, a);
    chk_ack(a, 1'b1);
    u_bus_ctl.stop();
    read2(7'h05, 8'h3c, 8'hff);
  endtask : t_abort

  task automatic t_erase;
    write_word(`TOTAL_ERASE_ADDR, `ERASED_WORD, 1'b1);
    repeat (PH + 20) @(posedge clock);
    #1;
    sel_open = 1'b0;
    read2(7'h05, 8'hff, 8'hff);
  endtask : t_erase

  initial begin
    rst_n     = 1'b0;
    sel_open  = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    t_program();
    t_refuse();
    t_abort();
    t_erase();
    stop_test();
  end

  initial begin
    // The traffic takes about 2.3 ms; the limit leaves some slack.
    #2700000;
    bad_count++;
    stop_test();
  end
endmodule : tb
